// ### include/rai_pkg.sv
// Register map, field positions and reset values of the alarm interrupt block
package rai_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] RAI_OFS_ALM_MIN  = 8'h00;
   localparam logic [7:0] RAI_OFS_ALM_HOUR = 8'h04;
   localparam logic [7:0] RAI_OFS_ALM_DAY  = 8'h08;
   localparam logic [7:0] RAI_OFS_CTRL     = 8'h0c;
   localparam logic [7:0] RAI_OFS_FLAG     = 8'h10;
   localparam logic [7:0] RAI_OFS_TIME     = 8'h14;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int RAI_WILDCARD_BIT   = 7;
   localparam int RAI_CTRL_AIE_BIT   = 0;
   localparam int RAI_CTRL_WDS_BIT   = 1;
   localparam int RAI_CTRL_RST_BIT   = 2;
   localparam int RAI_CTRL_TIE_BIT   = 3;
   localparam int RAI_CTRL_UIE_BIT   = 4;
   localparam int RAI_CTRL_EIE_BIT   = 5;
   localparam int RAI_FLAG_AF_BIT    = 0;
   localparam int RAI_FLAG_TF_BIT    = 1;
   localparam int RAI_FLAG_UF_BIT    = 2;
   localparam int RAI_FLAG_EF_BIT    = 3;
   localparam int RAI_CTRL_W         = 6;

   // Field widths of the compared counters
   localparam int RAI_MIN_W  = 7;
   localparam int RAI_HOUR_W = 6;
   localparam int RAI_DAYS_W = 7;
   localparam int RAI_DATE_W = 6;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [7:0]          RAI_ALM_RST  = 8'h00;
   localparam logic [RAI_CTRL_W-1:0] RAI_CTRL_RST = 6'h00;

endpackage : rai_pkg

// ### hw/rai_alarm_irq.sv
// Alarm compare, sticky alarm flag and shared open-drain interrupt with APB registers
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps

module rai_alarm_irq #(
   parameter int ADDR_W = 8                                  // APB address width
) (
   input  wire logic                        pclk,            // Bus and timekeeping clock
   input  wire logic                        presetn,         // Asynchronous reset, active low
   input  wire logic                        psel,            // APB select
   input  wire logic                        penable,         // APB access phase
   input  wire logic                        pwrite,          // APB direction, 1 = write
   input  wire logic [ADDR_W-1:0]           paddr,           // APB byte address
   input  wire logic [31:0]                 pwdata,          // APB write data
   output logic      [31:0]                 prdata,          // APB read data
   output logic                             pready,          // APB transfer done
   output logic                             pslverr,         // APB error, unmapped address
   input  wire logic                        min_update,      // Pulse: minute counter advanced
   input  wire logic [rai_pkg::RAI_MIN_W-1:0]  cur_min,      // BCD minute counter
   input  wire logic [rai_pkg::RAI_HOUR_W-1:0] cur_hour,     // BCD hour counter
   input  wire logic [rai_pkg::RAI_DAYS_W-1:0] cur_weekday,  // One-hot weekday counter
   input  wire logic [rai_pkg::RAI_DATE_W-1:0] cur_date,     // BCD day-of-month counter
   input  wire logic                        wakeup_timer_flag,   // Pending wakeup timer event
   input  wire logic                        time_update_flag,    // Pending time update event
   input  wire logic                        external_event_flag, // Pending event_input_pin event
   output logic                             int_n_o,         // Interrupt line drive value
   output logic                             int_n_oe         // Interrupt line pulled low when high
);
   import rai_pkg::*;

   // ------------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------------
   if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
      $error("rai_alarm_irq: ADDR_W must lie between 5 and 32");
   end

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]            alm_min;
      logic [7:0]            alm_hour;
      logic [7:0]            alm_day;
      logic [RAI_CTRL_W-1:0] ctrl;
      logic                  alarm_event_flag;
      logic                  int_oe;
      logic                  int_lvl;
      logic [31:0]           rdata;
      logic                  ready;
      logic                  slverr;
   } rai_state_s;

   rai_state_s st_r;
   rai_state_s st_nxt;

   // ------------------------------------------------------------------
   // Decode and compare
   // ------------------------------------------------------------------
   logic [7:0]  ofs;
   logic        acc_done;
   logic        wr_en;
   logic        hit;
   logic        min_ok;
   logic        hour_ok;
   logic        day_ok;
   logic        alarm_event;
   logic        alarm_irq_enable;
   logic        weekday_or_date_select;
   logic        ctrl_reset;

   assign ofs                    = 8'(paddr);
   assign acc_done               = psel & penable & st_r.ready;
   assign wr_en                  = acc_done & pwrite;
   assign alarm_irq_enable       = st_r.ctrl[RAI_CTRL_AIE_BIT];
   assign weekday_or_date_select = st_r.ctrl[RAI_CTRL_WDS_BIT];
   assign ctrl_reset             = st_r.ctrl[RAI_CTRL_RST_BIT];

   // Any address bit above the low byte set makes the access unmapped
   assign hit = ((ofs == RAI_OFS_ALM_MIN) || (ofs == RAI_OFS_ALM_HOUR) || (ofs == RAI_OFS_ALM_DAY) ||
                 (ofs == RAI_OFS_CTRL) || (ofs == RAI_OFS_FLAG) || (ofs == RAI_OFS_TIME)) &&
                ((ADDR_W <= 8) || ((paddr >> 8) == '0));

   // Wildcard fields always match
   assign min_ok  = st_r.alm_min[RAI_WILDCARD_BIT] ||
                    (st_r.alm_min[RAI_MIN_W-1:0] == cur_min);
   assign hour_ok = st_r.alm_hour[RAI_WILDCARD_BIT] ||
                    (st_r.alm_hour[RAI_HOUR_W-1:0] == cur_hour);

   always_comb begin
      if (st_r.alm_day[RAI_WILDCARD_BIT]) begin
         day_ok = 1'b1;
      end else if (weekday_or_date_select) begin
         day_ok = (st_r.alm_day[RAI_DATE_W-1:0] == cur_date);
      end else begin
         day_ok = |(st_r.alm_day[RAI_DAYS_W-1:0] & cur_weekday);
      end
   end

   // Only evaluated when the minute counter steps, so a setting equal to the present time waits
   assign alarm_event = min_update & ~ctrl_reset & min_ok & hour_ok & day_ok;

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic [31:0] rd;
      logic        flag_n;
      logic [RAI_CTRL_W-1:0] ctrl_n;
      rd     = 32'h0000_0000;
      st_nxt = st_r;
      flag_n = st_r.alarm_event_flag;
      ctrl_n = st_r.ctrl;

      // APB answers in the second access cycle; data and error are registered
      st_nxt.ready  = psel & penable & ~st_r.ready;
      st_nxt.slverr = psel & penable & ~st_r.ready & ~hit;

      if (ofs == RAI_OFS_ALM_MIN) begin
         rd = {24'h00_0000, st_r.alm_min};
      end else if (ofs == RAI_OFS_ALM_HOUR) begin
         rd = {24'h00_0000, st_r.alm_hour};
      end else if (ofs == RAI_OFS_ALM_DAY) begin
         rd = {24'h00_0000, st_r.alm_day};
      end else if (ofs == RAI_OFS_CTRL) begin
         rd = {26'h000_0000, st_r.ctrl};
      end else if (ofs == RAI_OFS_FLAG) begin
         rd = {28'h000_0000, external_event_flag, time_update_flag,
               wakeup_timer_flag, st_r.alarm_event_flag};
      end else if (ofs == RAI_OFS_TIME) begin
         rd = {2'b00, cur_date, 1'b0, cur_weekday, 2'b00, cur_hour, 1'b0, cur_min};
      end
      if (!hit) begin
         rd = 32'h0000_0000;
      end
      if (psel && penable && !st_r.ready && !pwrite) begin
         st_nxt.rdata = rd;
      end

      if (wr_en && hit) begin
         if (ofs == RAI_OFS_ALM_MIN) begin
            st_nxt.alm_min = pwdata[7:0];
         end else if (ofs == RAI_OFS_ALM_HOUR) begin
            st_nxt.alm_hour = pwdata[7:0];
         end else if (ofs == RAI_OFS_ALM_DAY) begin
            st_nxt.alm_day = pwdata[7:0];
         end else if (ofs == RAI_OFS_CTRL) begin
            ctrl_n = pwdata[RAI_CTRL_W-1:0];
         end else if (ofs == RAI_OFS_FLAG) begin
            if (!pwdata[RAI_FLAG_AF_BIT]) begin
               flag_n = 1'b0;
            end
         end
      end

      // A match in the clearing cycle still sets the flag
      if (alarm_event) begin
         flag_n = 1'b1;
      end

      st_nxt.ctrl             = ctrl_n;
      st_nxt.alarm_event_flag = flag_n;

      // Line follows next flags and enables, so release and assertion take effect at once
      st_nxt.int_oe = (flag_n & ctrl_n[RAI_CTRL_AIE_BIT]) |
                      (wakeup_timer_flag & ctrl_n[RAI_CTRL_TIE_BIT]) |
                      (time_update_flag & ctrl_n[RAI_CTRL_UIE_BIT]) |
                      (external_event_flag & ctrl_n[RAI_CTRL_EIE_BIT]);
      st_nxt.int_lvl = 1'b0;
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.alm_min          <= RAI_ALM_RST;
         st_r.alm_hour         <= RAI_ALM_RST;
         st_r.alm_day          <= RAI_ALM_RST;
         st_r.ctrl             <= RAI_CTRL_RST;
         st_r.alarm_event_flag <= 1'b0;
         st_r.int_oe           <= 1'b0;
         st_r.int_lvl          <= 1'b0;
         st_r.rdata            <= 32'h0000_0000;
         st_r.ready            <= 1'b0;
         st_r.slverr           <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata   = st_r.rdata;
   assign pready   = st_r.ready;
   assign pslverr  = st_r.slverr;
   assign int_n_o  = st_r.int_lvl;
   assign int_n_oe = st_r.int_oe;

   // Unused signal kept from lint noise
   logic unused_ok;
   assign unused_ok = alarm_irq_enable;

endmodule : rai_alarm_irq

// ### dv/rai_alarm_irq_checker.sv
// Port-level assertions of the alarm interrupt block
`timescale 1ns/1ps
module rai_alarm_irq_checker
   import rai_pkg::*;
#(
   parameter int ADDR_W = 8                        // Address width
) (
   input wire logic              pclk,                // Clock
   input wire logic              presetn,             // Reset, active low
   input wire logic              psel,                // APB select
   input wire logic              penable,             // APB access
   input wire logic              pwrite,              // APB direction
   input wire logic [ADDR_W-1:0] paddr,               // APB address
   input wire logic [31:0]       pwdata,              // APB write data
   input wire logic              pready,              // APB done
   input wire logic              pslverr,             // APB error
   input wire logic              min_update,          // Minute tick
   input wire logic              wakeup_timer_flag,   // Other source
   input wire logic              time_update_flag,    // Other source
   input wire logic              external_event_flag, // Other source
   input wire logic              int_n_o,             // Line value
   input wire logic              int_n_oe             // Line pull
);
   logic wr_done;
   logic others;
   assign wr_done = psel && penable && pready && pwrite;
   assign others  = wakeup_timer_flag || time_update_flag || external_event_flag;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   ready_timing_a: assert property (psel && penable && !pready && $past(psel && !penable) |=> pready)
      else $error("ready late");
   ready_idle_a: assert property (!(psel && penable) |=> !pready) else $error("ready without access");
   error_unmapped_a: assert property (pready && paddr[7:0] > RAI_OFS_TIME |-> pslverr) else $error("no error");
   error_mapped_a: assert property (pready && paddr[7:0] <= RAI_OFS_TIME && paddr[1:0] == 2'b00 |-> !pslverr)
      else $error("false error");
   line_low_a: assert property (int_n_oe |-> !int_n_o) else $error("line not driven low");
   rise_cause_a: assert property ($rose(int_n_oe) |-> $past(min_update || wr_done || others))
      else $error("line pulled without cause");
   enable_drop_a: assert property (wr_done && paddr[7:0] == RAI_OFS_CTRL && pwdata[5:3] == 3'h0
      && !pwdata[0] |=> !int_n_oe) else $error("line held after enable drop");
   flag_clear_a: assert property (wr_done && paddr[7:0] == RAI_OFS_FLAG && !pwdata[0]
      && !min_update && !others |=> !int_n_oe) else $error("line held after flag clear");
   hold_low_a: assert property (int_n_oe && !wr_done && !others && !$past(others) |=> int_n_oe)
      else $error("line released alone");
   cover property (int_n_oe && !others);
   cover property (pslverr);
   cover property (wr_done && paddr[7:0] == RAI_OFS_FLAG);
endmodule : rai_alarm_irq_checker
bind rai_alarm_irq rai_alarm_irq_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .min_update(min_update), .wakeup_timer_flag(wakeup_timer_flag),
   .time_update_flag(time_update_flag), .external_event_flag(external_event_flag),
   .int_n_o(int_n_o), .int_n_oe(int_n_oe));

// ### dv/rai_host_model.sv
// Host side of the shared interrupt line with its pull-up
`timescale 1ns/1ps
module rai_host_model (
   input  wire logic int_n_o,  // Drive value from the block
   input  wire logic int_n_oe, // Pull enable from the block
   output logic      int_line  // Resolved line level
);
   // Released line is pulled up
   assign int_line = int_n_oe ? int_n_o : 1'b1;
endmodule : rai_host_model

// ### dv/tb_rai_alarm_irq.sv
// Self-checking bench of the alarm interrupt block
`timescale 1ns/1ps
module tb_rai_alarm_irq;
   import rai_pkg::*;
   typedef struct packed {
      logic [7:0] am, ah, ad;
      logic [5:0] ctl;
      logic [6:0] m;
      logic [5:0] h;
      logic [6:0] w;
      logic [5:0] d;
      logic       f;
   } rai_row_s;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, min_update, err;
   logic        tf, uf, ef, int_n_o, int_n_oe, int_line;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [6:0]  cur_min, cur_weekday;
   logic [5:0]  cur_hour, cur_date;
   int          miscompares, checks;
   rai_row_s    rows [9] = '{
      '{8'h30, 8'h07, 8'h3e, 6'h01, 7'h30, 6'h07, 7'h02, 6'h01, 1'b1},
      '{8'h30, 8'h07, 8'h3e, 6'h01, 7'h30, 6'h07, 7'h01, 6'h01, 1'b0},
      '{8'h80, 8'h07, 8'h41, 6'h01, 7'h12, 6'h07, 7'h40, 6'h01, 1'b1},
      '{8'h30, 8'h07, 8'h15, 6'h03, 7'h30, 6'h07, 7'h00, 6'h15, 1'b1},
      '{8'h30, 8'h07, 8'h15, 6'h03, 7'h30, 6'h07, 7'h00, 6'h14, 1'b0},
      '{8'h30, 8'h07, 8'h3e, 6'h05, 7'h30, 6'h07, 7'h02, 6'h01, 1'b0},
      '{8'h30, 8'h07, 8'h3e, 6'h00, 7'h30, 6'h07, 7'h02, 6'h01, 1'b1},
      '{8'h80, 8'h80, 8'h80, 6'h01, 7'h45, 6'h23, 7'h10, 6'h31, 1'b1},
      '{8'h30, 8'h07, 8'h80, 6'h01, 7'h30, 6'h08, 7'h02, 6'h01, 1'b0}};
   rai_alarm_irq u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .min_update(min_update), .cur_min(cur_min), .cur_hour(cur_hour), .cur_weekday(cur_weekday),
      .cur_date(cur_date), .wakeup_timer_flag(tf), .time_update_flag(uf), .external_event_flag(ef),
      .int_n_o(int_n_o), .int_n_oe(int_n_oe));
   rai_host_model u_host (.int_n_o(int_n_o), .int_n_oe(int_n_oe), .int_line(int_line));
   task automatic finish_test();
      if (miscompares == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask : apb
   task automatic tick();
      @(posedge pclk);
      min_update <= 1'b1;
      @(posedge pclk);
      min_update <= 1'b0;
      #1;
   endtask : tick
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      {psel, penable, pwrite, min_update, tf, uf, ef, presetn} = '0;
      {paddr, pwdata, cur_min, cur_weekday, cur_hour, cur_date} = '0;
      miscompares = 0;
      checks = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, RAI_OFS_FLAG, 32'h0);
      chk(rd, 32'h0);
      chk(32'(int_line), 32'h1);
      foreach (rows[i]) begin
         cur_min <= rows[i].m;
         cur_hour <= rows[i].h;
         cur_weekday <= rows[i].w;
         cur_date <= rows[i].d;
         apb(1'b1, RAI_OFS_FLAG, 32'h0);
         apb(1'b1, RAI_OFS_ALM_MIN, {24'h0, rows[i].am});
         apb(1'b1, RAI_OFS_ALM_HOUR, {24'h0, rows[i].ah});
         apb(1'b1, RAI_OFS_ALM_DAY, {24'h0, rows[i].ad});
         apb(1'b1, RAI_OFS_CTRL, {26'h0, rows[i].ctl});
         apb(1'b0, RAI_OFS_FLAG, 32'h0);
         chk(rd, 32'h0);
         tick();
         chk(32'(int_line), 32'(!(rows[i].f && rows[i].ctl[0])));
         apb(1'b0, RAI_OFS_FLAG, 32'h0);
         chk(rd, 32'(rows[i].f));
      end
      cur_hour <= 6'h07;
      tick();
      repeat (40) @(posedge pclk);
      #1;
      chk(32'(int_line), 32'h0);
      apb(1'b1, RAI_OFS_FLAG, 32'h1);
      apb(1'b0, RAI_OFS_FLAG, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, RAI_OFS_CTRL, 32'h0);
      chk(32'(int_line), 32'h1);
      apb(1'b1, RAI_OFS_CTRL, 32'h1);
      chk(32'(int_line), 32'h0);
      apb(1'b1, RAI_OFS_FLAG, 32'h0);
      chk(32'(int_line), 32'h1);
      tick();
      chk(32'(int_line), 32'h0);
      apb(1'b1, RAI_OFS_FLAG, 32'h0);
      apb(1'b1, RAI_OFS_CTRL, 32'h38);
      {tf, uf, ef} <= 3'b111;
      repeat (2) @(posedge pclk);
      #1;
      chk(32'(int_line), 32'h0);
      apb(1'b0, RAI_OFS_FLAG, 32'h0);
      chk(rd, 32'he);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b0, RAI_OFS_TIME, 32'h0);
      chk(rd, {2'b00, cur_date, 1'b0, cur_weekday, 2'b00, cur_hour, 1'b0, cur_min});
      apb(1'b1, RAI_OFS_CTRL, 32'h0);
      chk(32'(int_line), 32'h1);
      apb(1'b0, RAI_OFS_FLAG, 32'h0);
      chk(rd, 32'he);
      apb(1'b1, RAI_OFS_CTRL, 32'h38);
      repeat (2) @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      #1;
      chk({31'h0, int_n_oe}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, RAI_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      chk(32'(int_line), 32'h1);
      apb(1'b0, RAI_OFS_FLAG, 32'h0);
      chk(rd, 32'he);
      finish_test();
   end
endmodule : tb_rai_alarm_irq
